// >>> verif/flash_link_assertions.sv
// concurrent checks on the wires between flash host and flash device
`timescale 1ns/1ps
module flash_link_assertions (
  // clock and reset
  input logic       CLK_I,
  input logic       SYS_RST_I,
  // link wires
  input logic       select_n,
  input logic       sclk,
  input logic [3:0] host_io_o,
  input logic [3:0] host_io_oe_n,
  input logic [3:0] dev_io_o,
  input logic [3:0] dev_io_oe_n,
  input logic [3:0] io
);
  logic       sclk_d_r;
  logic [7:0] rises_r;

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  // counts clock rises in a frame; one byte is 8 rises on one line, 2 on four
  always_ff @(posedge CLK_I) begin
    sclk_d_r <= sclk;
    if (SYS_RST_I || select_n) rises_r <= 8'h00;
    else if (sclk && !sclk_d_r) rises_r <= rises_r + 8'h01;
  end

  property p_sclk_idle; select_n |-> !sclk; endproperty
  property p_frame_start; $fell(select_n) |-> !sclk [*8]; endproperty
  property p_host_drives; $fell(select_n) |-> ##[1:9] (host_io_oe_n != 4'hf); endproperty
  property p_io_stable; (!select_n && sclk && $past(sclk)) |-> $stable(io); endproperty
  property p_no_clash; (host_io_oe_n | dev_io_oe_n) == 4'hf; endproperty
  property p_sclk_high; $rose(sclk) |-> sclk [*4]; endproperty
  property p_sel_gap; $rose(select_n) |-> select_n [*2]; endproperty
  property p_host_release; $rose(select_n) |-> (host_io_oe_n == 4'hf); endproperty
  property p_dev_release; $rose(select_n) |-> ##[1:4] (dev_io_oe_n == 4'hf); endproperty
  property p_whole_bytes;
    $rose(select_n) |-> (rises_r != 8'h00) && (rises_r[0] == 1'b0);
  endproperty

  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock high outside a frame");
  a_frame_start: assert property (p_frame_start)
    else $error("serial clock too early after select");
  a_host_drives: assert property (p_host_drives)
    else $error("host not driving opcode after select");
  a_io_stable: assert property (p_io_stable)
    else $error("data lines moved while clock high");
  a_no_clash: assert property (p_no_clash)
    else $error("both ends drive one line");
  a_sclk_high: assert property (p_sclk_high)
    else $error("clock high phase too short");
  a_sel_gap: assert property (p_sel_gap)
    else $error("select high gap too short");
  a_host_release: assert property (p_host_release)
    else $error("host still drives at frame end");
  a_dev_release: assert property (p_dev_release)
    else $error("device did not release lines");
  a_whole_bytes: assert property (p_whole_bytes)
    else $error("frame ended off a byte boundary");

  c_dual: cover property (dev_io_oe_n == 4'hc);
  c_quad: cover property (dev_io_oe_n == 4'h0);
  c_one_byte: cover property ($rose(select_n) && rises_r == 8'h08);
endmodule // flash_link_assertions

// >>> verif/testbench.sv
// self-checking bench: flash host and device joined over the link
`timescale 1ns/1ps
module testbench;
  import flash_pkg::*;
  logic        clk, rst, cval, cwr, quad_r, busy, ready, rd_valid, done;
  logic        wel, vol, amode, susp, resm, pdn;
  logic [7:0]  opc, wdat, rd_data, ext, rd_byte;
  logic [2:0]  naddr, ndum, rdw;
  logic [3:0]  nrd;
  logic [31:0] addr, rd_addr;
  logic [7:0]  rdq[$];
  int          error_cnt, checks, sus_n, res_n, done_n, cyc;

  flash_link_if lnk ();
  flash_cmd_host u_flash_cmd_host (.CLK_I(clk), .SYS_RST_I(rst), .LNK(lnk),
    .CMD_VALID_I(cval), .CMD_OPC_I(opc), .CMD_QUAD_I(quad_r), .CMD_ADDR_I(addr),
    .CMD_NADDR_I(naddr), .CMD_NDUMMY_I(ndum), .CMD_WR_I(cwr), .CMD_WDATA_I(wdat),
    .CMD_NRD_I(nrd), .CMD_RDW_I(rdw), .CMD_READY_O(ready), .RD_VALID_O(rd_valid),
    .RD_DATA_O(rd_data), .DONE_O(done));
  flash_cmd_dev u_flash_cmd_dev (.CLK_I(clk), .SYS_RST_I(rst), .LNK(lnk),
    .FOUR_LINE_MODE_I(quad_r), .BUSY_I(busy), .STATUS_I(8'hc3), .RD_DATA_I(rd_byte),
    .RD_ADDR_O(rd_addr), .WEL_O(wel), .VOL_SR_WE_O(vol), .ADDR_MODE_O(amode),
    .EXT_ADDR_O(ext), .SUSPEND_O(susp), .RESUME_O(resm), .POWER_DOWN_O(pdn));
  flash_link_assertions u_flash_link_assertions (.CLK_I(clk), .SYS_RST_I(rst),
    .select_n(lnk.select_n), .sclk(lnk.sclk), .host_io_o(lnk.host_io_o),
    .host_io_oe_n(lnk.host_io_oe_n), .dev_io_o(lnk.dev_io_o),
    .dev_io_oe_n(lnk.dev_io_oe_n), .io(lnk.io));

  // array byte mixes top and bottom address bytes so both show in read data
  assign rd_byte = rd_addr[31:24] ^ rd_addr[7:0];

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (rd_valid === 1'b1) rdq.push_back(rd_data);
    if (susp === 1'b1) sus_n <= sus_n + 1;
    if (resm === 1'b1) res_n <= res_n + 1;
    if (done === 1'b1) done_n <= done_n + 1;
    if (cyc == 40000) begin
      error_cnt++;
      $display("unexpected at %0t: run did not finish", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (error_cnt == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // one whole command; returns once the host is ready again
  task automatic run(input int op, na, input logic [31:0] a, input int nd, wr, wd, nr, w);
    int d0;
    d0 = done_n;
    rdq.delete();
    opc   <= 8'(op);
    naddr <= 3'(na);
    addr  <= a;
    ndum  <= 3'(nd);
    cwr   <= 1'(wr);
    wdat  <= 8'(wd);
    nrd   <= 4'(nr);
    rdw   <= 3'(w);
    cval  <= 1'b1;
    @(posedge clk);
    cval <= 1'b0;
    @(posedge clk);
    while (ready !== 1'b1) @(posedge clk);
    repeat (2) @(posedge clk);
    chk(done_n, d0 + 1);
  endtask

  initial begin
    rst    = 1'b1;
    cval   = 1'b0;
    cwr    = 1'b0;
    quad_r = 1'b0;
    busy   = 1'b0;
    opc    = 8'h00;
    wdat   = 8'h00;
    naddr  = 3'h0;
    ndum   = 3'h0;
    rdw    = 3'h1;
    nrd    = 4'h0;
    addr   = 32'h0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(ext, 8'h00);
    run(8'h06, 0, 32'h0, 0, 0, 8'h00, 0, 1);
    chk(wel, 1'b1);
    run(8'h50, 0, 32'h0, 0, 0, 8'h00, 0, 1);
    chk(vol, 1'b1);
    run(8'h04, 0, 32'h0, 0, 0, 8'h00, 0, 1);
    chk(wel, 1'b0);
    chk(vol, 1'b0);
    run(8'hc5, 0, 32'h0, 0, 1, 8'ha5, 0, 1);
    chk(ext, 8'ha5);
    run(8'hc8, 0, 32'h0, 0, 0, 8'h00, 2, 1);
    chk(rdq[0], 8'ha5);
    chk(rdq[1], 8'ha5);
    run(8'h03, 3, 32'h00102030, 0, 0, 8'h00, 2, 1);
    chk(rdq[0], 8'h95);
    chk(rdq[1], 8'h94);
    run(8'hb7, 0, 32'h0, 0, 0, 8'h00, 0, 1);
    chk(amode, 1'b1);
    run(8'h03, 4, 32'h12000040, 0, 0, 8'h00, 1, 1);
    chk(rdq[0], 8'h52);
    chk(ext, 8'h12);
    run(8'he9, 0, 32'h0, 0, 0, 8'h00, 0, 1);
    chk(amode, 1'b0);
    run(8'h3c, 4, 32'h34000008, 1, 0, 8'h00, 2, 2);
    chk(rdq[0], 8'h3c);
    chk(rdq[1], 8'h3d);
    chk(ext, 8'h34);
    run(8'h6c, 4, 32'h5600000c, 1, 0, 8'h00, 2, 4);
    chk(rdq[0], 8'h5a);
    chk(rdq[1], 8'h5b);
    busy <= 1'b1;
    run(8'h75, 0, 32'h0, 0, 0, 8'h00, 0, 1);
    chk(sus_n, 1);
    run(8'h06, 0, 32'h0, 0, 0, 8'h00, 0, 1);
    chk(wel, 1'b0);
    run(8'h05, 0, 32'h0, 0, 0, 8'h00, 1, 1);
    chk(rdq[0], 8'hc3);
    busy <= 1'b0;
    run(8'h7a, 0, 32'h0, 0, 0, 8'h00, 0, 1);
    chk(res_n, 1);
    run(8'hff, 0, 32'h0, 0, 1, 8'h99, 0, 1);
    chk(ext, 8'h56);
    chk(wel, 1'b0);
    run(8'hb9, 0, 32'h0, 0, 0, 8'h00, 0, 1);
    chk(pdn, 1'b1);
    run(8'hab, 0, 32'h0, 3, 0, 8'h00, 1, 1);
    chk(rdq[0], DEV_ID_DEFAULT);
    chk(pdn, 1'b0);
    quad_r <= 1'b1;
    run(8'hc5, 0, 32'h0, 0, 1, 8'h3c, 0, 4);
    chk(ext, 8'h3c);
    run(8'hc8, 0, 32'h0, 0, 0, 8'h00, 1, 4);
    chk(rdq[0], 8'h3c);
    run(8'h06, 0, 32'h0, 0, 0, 8'h00, 0, 4);
    chk(wel, 1'b1);
    quad_r <= 1'b0;
    report_and_stop();
  end
endmodule // testbench

// >>> verilog/flash_cmd_dev.sv
// serial flash instruction decoder, device end of the link
// ****************************************
// ****************************************
`timescale 1ns/1ps
module flash_cmd_dev
  import flash_pkg::*;
#(
  parameter logic [7:0] DEV_ID = DEV_ID_DEFAULT
) (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  // link
  flash_link_if.dev        LNK,
  // array side
  input  wire logic        FOUR_LINE_MODE_I,
  input  wire logic        BUSY_I,
  input  wire logic [7:0]  STATUS_I,
  input  wire logic [7:0]  RD_DATA_I,
  output logic      [31:0] RD_ADDR_O,
  // decoded state and events
  output logic             WEL_O,
  output logic             VOL_SR_WE_O,
  output logic             ADDR_MODE_O,
  output logic      [7:0]  EXT_ADDR_O,
  output logic             SUSPEND_O,
  output logic             RESUME_O,
  output logic             POWER_DOWN_O
);

  typedef enum logic [2:0] {
    ST_OPC, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA, ST_DONE, ST_IGNORE
  } dstate_e;

  // ****************************************
  // declarations
  // ****************************************
  logic        cs_m, cs_s, cs_d;
  logic        ck_m, ck_s, ck_d;
  logic [3:0]  io_m, io_s;
  dstate_e     state_r;
  logic [7:0]  opc_r;
  logic [7:0]  sh_r;
  logic [2:0]  nbit_r;
  logic [2:0]  cnt_r;
  logic        four_r;
  logic [31:0] addr_r;
  logic [7:0]  data_r;
  logic [7:0]  odat_r;
  logic [2:0]  obit_r;
  logic [3:0]  dout_r;
  logic [3:0]  doe_n_r;
  logic [31:0] rd_addr_r;
  logic        wel_r, vsr_r, amode_r, pwrdn_r, susp_r, res_r;
  logic [7:0]  ext_r;

  // ****************************************
  // functions
  // ****************************************
  function automatic dstate_e route_op(input logic [7:0] op);
    case (op)
      OP_WR_EN, OP_VOL_SR_EN, OP_WR_DIS, OP_ADDR4_ON, OP_ADDR4_OFF,
      OP_SUSPEND, OP_RESUME, OP_PWR_DOWN:          route_op = ST_DONE;
      OP_WR_EXT:                                   route_op = ST_WDATA;
      OP_RD_EXT, OP_RD_STATUS:                     route_op = ST_RDATA;
      OP_RELEASE_ID:                               route_op = ST_DUMMY;
      OP_READ, OP_READ4_DUAL, OP_READ4_QUAD:       route_op = ST_ADDR;
      default:                                     route_op = ST_IGNORE;
    endcase
  endfunction

  // output lines: single on the SO line, dual on 1:0, quad on 3:0
  function automatic logic [3:0] place_bits(input logic [7:0] b, input logic [2:0] w);
    case (w)
      3'd4:    place_bits = b[7:4];
      3'd2:    place_bits = {2'b00, b[7:6]};
      default: place_bits = {2'b00, b[7], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] oe_mask_n(input logic [2:0] w);
    case (w)
      3'd4:    oe_mask_n = 4'h0;
      3'd2:    oe_mask_n = 4'hc;
      default: oe_mask_n = 4'hf & ~(4'h1 << SO_LINE);
    endcase
  endfunction

  // ****************************************
  // decode
  // ****************************************
  wire        rise     = ck_s & ~ck_d & ~cs_s;
  wire        fall     = ~ck_s & ck_d & ~cs_s;
  wire        cs_end   = cs_s & ~cs_d;
  wire        quad     = FOUR_LINE_MODE_I;
  wire [2:0]  in_step  = quad ? 3'd4 : 3'd1;
  wire [7:0]  sh_nxt   = quad ? {sh_r[3:0], io_s}
                              : {sh_r[6:0], io_s[SI_LINE]};
  wire [2:0]  nbit_nxt = nbit_r + in_step;
  wire        byte_done = rise && (nbit_nxt == 3'd0);
  wire        four_op  = amode_r || sh_nxt == OP_READ4_DUAL
                       || sh_nxt == OP_READ4_QUAD;
  wire        allowed  = (!BUSY_I || sh_nxt == OP_RD_STATUS
                          || sh_nxt == OP_SUSPEND)
                       && (!pwrdn_r || sh_nxt == OP_RELEASE_ID);
  wire [2:0]  first_cnt = (sh_nxt == OP_RELEASE_ID) ? ID_DUMMY_BYTES
                        : four_op ? ADDR4_BYTES : ADDR3_BYTES;
  wire [31:0] addr_full = {addr_r[23:0], sh_nxt};
  wire        addr_end = byte_done && state_r == ST_ADDR && cnt_r == 3'd1;
  wire        id_wake  = byte_done && state_r == ST_DUMMY && cnt_r == 3'd1
                       && opc_r == OP_RELEASE_ID;
  // writes act only on a clean byte boundary at select release
  wire        exec     = cs_end && state_r == ST_DONE && nbit_r == 3'd0;
  wire [2:0]  out_w    = quad ? 3'd4
                       : (opc_r == OP_READ4_DUAL) ? 3'd2
                       : (opc_r == OP_READ4_QUAD) ? 3'd4
                       : 3'd1;
  wire        mem_rd   = opc_r == OP_READ || opc_r == OP_READ4_DUAL
                       || opc_r == OP_READ4_QUAD;
  wire [7:0]  src_byte = (opc_r == OP_RD_EXT)     ? ext_r
                       : (opc_r == OP_RD_STATUS)  ? STATUS_I
                       : (opc_r == OP_RELEASE_ID) ? DEV_ID
                       : RD_DATA_I;
  wire [7:0]  cur_byte = (obit_r == 3'd0) ? src_byte : odat_r;
  wire        out_fall = fall && state_r == ST_RDATA;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      {cs_m, cs_s, cs_d} <= 3'b111;
      {ck_m, ck_s, ck_d} <= 3'b000;
      io_m               <= 4'hf;
      io_s               <= 4'hf;
    end else begin
      cs_m <= LNK.select_n;
      cs_s <= cs_m;
      cs_d <= cs_s;
      ck_m <= LNK.sclk;
      ck_s <= ck_m;
      ck_d <= ck_s;
      io_m <= LNK.io;
      io_s <= io_m;
    end
  end

  // ****************************************
  // frame sequencer
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || cs_end) begin
      // a new frame always opens with the opcode
      state_r <= ST_OPC;
      nbit_r  <= 3'd0;
      if (SYS_RST_I) begin
        opc_r  <= 8'h00;
        sh_r   <= 8'h00;
        cnt_r  <= 3'd0;
        four_r <= 1'b0;
        addr_r <= 32'h0;
        data_r <= 8'h00;
      end
    end else if (rise) begin
      sh_r   <= sh_nxt;
      nbit_r <= nbit_nxt;
      if (byte_done) begin
        case (state_r)
          ST_OPC: begin
            opc_r   <= sh_nxt;
            four_r  <= four_op;
            cnt_r   <= first_cnt;
            state_r <= allowed ? route_op(sh_nxt) : ST_IGNORE;
          end
          ST_ADDR: begin
            addr_r <= addr_full;
            cnt_r  <= cnt_r - 3'd1;
            if (cnt_r == 3'd1) begin
              cnt_r   <= FAST_DUMMY;
              state_r <= (opc_r == OP_READ) ? ST_RDATA : ST_DUMMY;
            end
          end
          ST_DUMMY: begin
            cnt_r <= cnt_r - 3'd1;
            if (cnt_r == 3'd1) begin
              state_r <= ST_RDATA;
            end
          end
          ST_WDATA: begin
            data_r  <= sh_nxt;
            state_r <= ST_DONE;
          end
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // output shifter: lines change on falling clock
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I || cs_s) begin
      // any bit may end a read, so release on select alone
      doe_n_r <= 4'hf;
      dout_r  <= 4'h0;
      obit_r  <= 3'd0;
      odat_r  <= 8'h00;
    end else if (out_fall) begin
      dout_r  <= place_bits(cur_byte, out_w);
      doe_n_r <= oe_mask_n(out_w);
      odat_r  <= cur_byte << out_w;
      obit_r  <= obit_r + out_w;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rd_addr_r <= 32'h0;
    end else if (addr_end) begin
      // three-byte mode takes the top byte from the extended register
      rd_addr_r <= four_r ? addr_full : {ext_r, addr_full[23:0]};
    end else if (out_fall && obit_r == 3'd0 && mem_rd) begin
      rd_addr_r <= rd_addr_r + 32'd1;
    end
  end

  // ****************************************
  // command effects
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      wel_r   <= 1'b0;
      vsr_r   <= 1'b0;
      amode_r <= 1'b0;
      pwrdn_r <= 1'b0;
      susp_r  <= 1'b0;
      res_r   <= 1'b0;
      ext_r   <= EXT_ADDR_RST;
    end else begin
      susp_r <= 1'b0;
      res_r  <= 1'b0;
      if (addr_end && four_r) begin
        ext_r <= addr_full[31:24];
      end
      if (id_wake) begin
        pwrdn_r <= 1'b0;
      end
      if (exec) begin
        case (opc_r)
          OP_WR_EN:     wel_r   <= 1'b1;
          OP_VOL_SR_EN: vsr_r   <= 1'b1;
          OP_WR_DIS: begin
            wel_r <= 1'b0;
            vsr_r <= 1'b0;
          end
          OP_ADDR4_ON:  amode_r <= 1'b1;
          OP_ADDR4_OFF: amode_r <= 1'b0;
          OP_SUSPEND:   susp_r  <= 1'b1;
          OP_RESUME:    res_r   <= 1'b1;
          OP_PWR_DOWN:  pwrdn_r <= 1'b1;
          OP_WR_EXT:    ext_r   <= data_r;
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign LNK.dev_io_o    = dout_r;
  assign LNK.dev_io_oe_n = doe_n_r;
  assign RD_ADDR_O       = rd_addr_r;
  assign WEL_O           = wel_r;
  assign VOL_SR_WE_O     = vsr_r;
  assign ADDR_MODE_O     = amode_r;
  assign EXT_ADDR_O      = ext_r;
  assign SUSPEND_O       = susp_r;
  assign RESUME_O        = res_r;
  assign POWER_DOWN_O    = pwrdn_r;

endmodule // flash_cmd_dev

// >>> verilog/flash_cmd_host.sv
// serial flash host controller, far end of the link
`timescale 1ns/1ps
module flash_cmd_host
  import flash_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        SYS_RST_I,
  // link
  flash_link_if.host       LNK,
  // command request
  input  wire logic        CMD_VALID_I,
  input  wire logic [7:0]  CMD_OPC_I,
  input  wire logic        CMD_QUAD_I,
  input  wire logic [31:0] CMD_ADDR_I,
  input  wire logic [2:0]  CMD_NADDR_I,
  input  wire logic [2:0]  CMD_NDUMMY_I,
  input  wire logic        CMD_WR_I,
  input  wire logic [7:0]  CMD_WDATA_I,
  input  wire logic [3:0]  CMD_NRD_I,
  input  wire logic [2:0]  CMD_RDW_I,
  output logic             CMD_READY_O,
  // answers
  output logic             RD_VALID_O,
  output logic      [7:0]  RD_DATA_O,
  output logic             DONE_O
);

  typedef enum logic [1:0] {H_IDLE, H_RUN, H_END} hstate_e;

  // ****************************************
  // declarations
  // ****************************************
  hstate_e     st_r;
  logic [3:0]  tc_r;
  logic        sclk_r, cs_r, lead_r, rxp_r;
  logic [3:0]  io_o_r, oe_n_r, io_m, io_s;
  logic [7:0]  opc_r, wdata_r, rx_sh_r, rdd_r;
  logic [31:0] addr_r;
  logic [2:0]  naddr_r, ndum_r, rdw_r, bbit_r, rbit_r;
  logic        quad_r, wr_r, rdv_r, done_r, ready_r;
  logic [3:0]  bidx_r, left_r;

  // all inputs are arguments so the continuous assign below follows every change
  function automatic logic [7:0] tx_byte(input logic [3:0]  i,
                                         input logic [7:0]  opc,
                                         input logic [31:0] a,
                                         input logic [2:0]  na,
                                         input logic [2:0]  nd,
                                         input logic [7:0]  wd);
    logic [1:0] k;
    k = 2'(na - i[2:0]);
    if (i == 4'd0) tx_byte = opc;
    else if (i <= {1'b0, na}) tx_byte = a[{k, 3'b000} +: 8];
    else if (i <= {1'b0, na} + {1'b0, nd}) tx_byte = 8'h00;
    else tx_byte = wd;
  endfunction

  // ****************************************
  // decode
  // ****************************************
  wire       tick    = tc_r == 4'(SCLK_HALF_CYC - 1);
  wire [3:0] tx_len  = 4'd1 + {1'b0, naddr_r} + {1'b0, ndum_r} + {3'b000, wr_r};
  wire [2:0] tx_step = quad_r ? 3'd4 : 3'd1;
  wire [7:0] tx_sh   = tx_byte(bidx_r, opc_r, addr_r, naddr_r, ndum_r, wdata_r) << bbit_r;
  wire [2:0] rx_w    = quad_r ? 3'd4 : rdw_r;
  wire [7:0] rx_nxt  = (rx_w == 3'd4) ? {rx_sh_r[3:0], io_s}
                     : (rx_w == 3'd2) ? {rx_sh_r[5:0], io_s[1:0]}
                     : {rx_sh_r[6:0], io_s[SO_LINE]};
  wire       tx_done = bidx_r == tx_len;
  wire       finish  = (rxp_r || tx_done) && left_r == 4'd0;
  wire       accept  = st_r == H_IDLE && CMD_VALID_I && ready_r;
  wire       do_fall = st_r == H_RUN && tick && (sclk_r || lead_r);
  wire       do_rise = st_r == H_RUN && tick && !sclk_r && !lead_r;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      io_m <= 4'hf;
      io_s <= 4'hf;
    end else begin
      io_m <= LNK.io;
      io_s <= io_m;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      st_r <= H_IDLE;
      {tc_r, sclk_r, cs_r, lead_r, rxp_r} <= {4'd0, 1'b0, 1'b1, 1'b0, 1'b0};
      {io_o_r, oe_n_r, bidx_r, bbit_r, rbit_r} <= {4'h0, 4'hf, 4'd0, 3'd0, 3'd0};
      {rdv_r, done_r, ready_r, rx_sh_r, rdd_r} <= {3'b001, 8'h00, 8'h00};
      {opc_r, wdata_r, addr_r, left_r} <= {8'h00, 8'h00, 32'h0, 4'd0};
      {naddr_r, ndum_r, rdw_r, quad_r, wr_r} <= {3'd0, 3'd0, 3'd1, 1'b0, 1'b0};
    end else begin
      rdv_r  <= 1'b0;
      done_r <= 1'b0;
      tc_r   <= (tick || st_r == H_IDLE) ? 4'd0 : tc_r + 4'd1;
      if (accept) begin
        {opc_r, addr_r, naddr_r, ndum_r} <= {CMD_OPC_I, CMD_ADDR_I, CMD_NADDR_I, CMD_NDUMMY_I};
        {wr_r, wdata_r, left_r} <= {CMD_WR_I, CMD_WDATA_I, CMD_NRD_I};
        {quad_r, rdw_r} <= {CMD_QUAD_I, CMD_RDW_I};
        {bidx_r, bbit_r, rbit_r, rxp_r} <= {4'd0, 3'd0, 3'd0, 1'b0};
        cs_r    <= 1'b0;
        lead_r  <= 1'b1;
        ready_r <= 1'b0;
        st_r    <= H_RUN;
      end
      if (st_r == H_END && tick) begin
        st_r    <= H_IDLE;
        ready_r <= 1'b1;
      end
      if (do_fall) begin
        sclk_r <= 1'b0;
        lead_r <= 1'b0;
        if (finish) begin
          // whole bytes only, so write commands are never cut short
          cs_r   <= 1'b1;
          oe_n_r <= 4'hf;
          done_r <= 1'b1;
          st_r   <= H_END;
        end else if (tx_done || rxp_r) begin
          rxp_r  <= 1'b1;
          oe_n_r <= 4'hf;
        end else begin
          io_o_r <= quad_r ? tx_sh[7:4] : {3'b000, tx_sh[7]};
          oe_n_r <= quad_r ? 4'h0 : 4'hf & ~(4'h1 << SI_LINE);
          bbit_r <= bbit_r + tx_step;
          if (3'(bbit_r + tx_step) == 3'd0) begin
            bidx_r <= bidx_r + 4'd1;
          end
        end
      end
      if (do_rise) begin
        sclk_r <= 1'b1;
        if (rxp_r) begin
          rx_sh_r <= rx_nxt;
          rbit_r  <= rbit_r + rx_w;
          if (3'(rbit_r + rx_w) == 3'd0) begin
            rdd_r  <= rx_nxt;
            rdv_r  <= 1'b1;
            left_r <= left_r - 4'd1;
          end
        end
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign LNK.select_n     = cs_r;
  assign LNK.sclk         = sclk_r;
  assign LNK.host_io_o    = io_o_r;
  assign LNK.host_io_oe_n = oe_n_r;
  assign CMD_READY_O      = ready_r;
  assign RD_VALID_O       = rdv_r;
  assign RD_DATA_O        = rdd_r;
  assign DONE_O           = done_r;

endmodule // flash_cmd_host

// >>> verilog/flash_link_if.sv
// link wires between flash host controller and flash device
`timescale 1ns/1ps
interface flash_link_if;
  logic       select_n;
  logic       sclk;
  logic [3:0] host_io_o;
  logic [3:0] host_io_oe_n;
  logic [3:0] dev_io_o;
  logic [3:0] dev_io_oe_n;
  logic [3:0] io;

  // resolved quad lines: weak pull-up when nobody drives
  assign io = (~host_io_oe_n & host_io_o) | (~dev_io_oe_n & dev_io_o)
            | (host_io_oe_n & dev_io_oe_n);

  modport dev (input select_n, input sclk, input io, output dev_io_o, output dev_io_oe_n);
  modport host (output select_n, output sclk, output host_io_o, output host_io_oe_n,
                input io);
endinterface

// >>> verilog/flash_pkg.sv
// shared constants for the serial flash command link
package flash_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS  = 100;
  // host-made serial clock; slow enough for two-stage input sync on both ends
  localparam int SCLK_PERIOD_NS = 1600;
  localparam int SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // ****************************************
  // opcodes
  // ****************************************
  localparam logic [7:0] OP_WR_EN      = 8'h06;
  localparam logic [7:0] OP_VOL_SR_EN  = 8'h50;
  localparam logic [7:0] OP_WR_DIS     = 8'h04;
  localparam logic [7:0] OP_RD_STATUS  = 8'h05;
  localparam logic [7:0] OP_RD_EXT     = 8'hc8;
  localparam logic [7:0] OP_WR_EXT     = 8'hc5;
  localparam logic [7:0] OP_ADDR4_ON   = 8'hb7;
  localparam logic [7:0] OP_ADDR4_OFF  = 8'he9;
  localparam logic [7:0] OP_SUSPEND    = 8'h75;
  localparam logic [7:0] OP_RESUME     = 8'h7a;
  localparam logic [7:0] OP_PWR_DOWN   = 8'hb9;
  localparam logic [7:0] OP_RELEASE_ID = 8'hab;
  localparam logic [7:0] OP_READ       = 8'h03;
  localparam logic [7:0] OP_READ4_DUAL = 8'h3c;
  localparam logic [7:0] OP_READ4_QUAD = 8'h6c;

  // ****************************************
  // byte counts, lines, reset values
  // ****************************************
  localparam logic [2:0] ADDR3_BYTES    = 3'd3;
  localparam logic [2:0] ADDR4_BYTES    = 3'd4;
  localparam logic [2:0] ID_DUMMY_BYTES = 3'd3;
  localparam logic [2:0] FAST_DUMMY     = 3'd1;
  localparam int         SI_LINE        = 0;
  localparam int         SO_LINE        = 1;
  localparam logic [7:0] EXT_ADDR_RST   = 8'h00;
  // identification byte: value is arbitrary
  localparam logic [7:0] DEV_ID_DEFAULT = 8'h5a;

endpackage
